//--- rtl/isr_filt_counter.sv
`timescale 1ns/1ps
module isr_filt_counter (
    input  wire logic                        hclk,     // core clock
    input  wire logic                        hresetn,  // async reset, low
    input  wire logic                        ce,       // clock enable
    input  wire logic                        inc,      // one filtered packet
    input  wire logic                        clr,      // clearing read
    output logic [isr_pkg::CNT_W-1:0]        count     // current value
);

    // ==========================================================
    // saturating count, clear on read
    // an event in the clearing cycle survives as a count of one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= isr_pkg::CNT_RESET;
        end else if (ce) begin
            if (clr) begin
                count <= inc ? isr_pkg::CNT_W'(1) : isr_pkg::CNT_RESET;
            end else if (inc && count != isr_pkg::CNT_MAX) begin
                count <= count + isr_pkg::CNT_W'(1);
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_cnt_inc;
        ce && inc && !clr && count != isr_pkg::CNT_MAX |=> count == $past(count) + isr_pkg::CNT_W'(1);
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter missed an event");

    property p_cnt_sat;
        count == isr_pkg::CNT_MAX && !(ce && clr) |=> count == isr_pkg::CNT_MAX;
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("counter left its maximum");

    property p_cnt_clr;
        ce && clr && !inc |=> count == isr_pkg::CNT_RESET;
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("read did not clear counter");

    property p_cnt_keep;
        ce && clr && inc |=> count == isr_pkg::CNT_W'(1);
    endproperty
    a_cnt_keep: assert property (p_cnt_keep) else $error("event lost on clear");

    property p_cov_sat;
        ce && inc && count == isr_pkg::CNT_MAX;
    endproperty
    c_cov_sat: cover property (p_cov_sat);

endmodule : isr_filt_counter

//--- rtl/isr_pkg.sv
package isr_pkg;

    // ==========================================================
    // register indexes (byte address is four times the index)
    localparam logic [15:0] IDX_RATE_STATUS  = 16'h184C;
    localparam logic [15:0] IDX_RATE_RD_DATA = 16'h184E;
    localparam logic [15:0] IDX_FILT_CNT_P0  = 16'h1850;
    localparam logic [15:0] IDX_FILT_CNT_P1  = 16'h1851;
    localparam logic [15:0] IDX_FILT_CNT_P2  = 16'h1852;
    localparam logic [15:0] IDX_REGEN_P0     = 16'h1855;
    localparam logic [15:0] IDX_REGEN_P1     = 16'h1856;
    localparam int unsigned IDX_W            = 16;

    // ==========================================================
    // field layout
    localparam int unsigned PRIO_W       = 3;
    localparam int unsigned NUM_PRIO     = 8;
    localparam int unsigned REGEN_W      = 24;
    localparam int unsigned RATE_DATA_W  = 16;
    localparam int unsigned CNT_W        = 32;
    localparam int unsigned PENDING_BIT  = 0;

    // ==========================================================
    // reset values
    localparam logic [31:0] CNT_RESET     = 32'h0000_0000;
    localparam logic [31:0] CNT_MAX       = 32'hFFFF_FFFF;
    localparam logic [15:0] RATE_RD_RESET = 16'h0000;
    localparam logic [23:0] REGEN_RESET   = 24'hFAC688;  // field n holds n

    // ==========================================================
    // bus encodings
    localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
    localparam logic [1:0]  HRESP_OKAY    = 2'h0;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic               valid;   // one-cycle packet strobe
        logic [PRIO_W-1:0]  prio;    // vlan priority
    } isr_pkt_t;

    typedef struct packed {
        logic filtered;              // dropped by an ingress filter
        logic bcast_throttle;        // dropped by broadcast throttling
    } isr_drop_t;

endpackage : isr_pkg

//--- rtl/isr_regen_map.sv
`timescale 1ns/1ps
module isr_regen_map (
    input  wire logic                          hclk,      // core clock
    input  wire logic                          hresetn,   // async reset, low
    input  wire logic                          ce,        // clock enable
    input  wire logic [isr_pkg::REGEN_W-1:0]   table_bits,// eight 3-bit fields
    input  wire isr_pkg::isr_pkt_t             pkt_in,    // received priority
    output isr_pkg::isr_pkt_t                  pkt_out    // regenerated priority
);

    logic [isr_pkg::PRIO_W-1:0] next_prio;

    // ==========================================================
    // pick field n for priority n
    always_comb begin
        next_prio = table_bits[pkt_in.prio*isr_pkg::PRIO_W +: isr_pkg::PRIO_W];
    end

    // registered so queue selection sees a clean value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pkt_out <= '0;
        end else if (ce) begin
            pkt_out.valid <= pkt_in.valid;
            pkt_out.prio  <= pkt_in.valid ? next_prio : pkt_out.prio;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_map;
        ce && pkt_in.valid |=> pkt_out.valid &&
            pkt_out.prio == isr_pkg::PRIO_W'($past(table_bits) >> (isr_pkg::PRIO_W * $past(pkt_in.prio)));
    endproperty
    a_map: assert property (p_map) else $error("priority not taken from table");

    property p_cov_remap;
        ce && pkt_in.valid && next_prio != pkt_in.prio;
    endproperty
    c_cov_remap: cover property (p_cov_remap);

endmodule : isr_regen_map

//--- rtl/isr_regs.sv
// Summary of operation
// - rate read data shows fetched table entry in bits 15:0, upper bits zero
// - pending flag set while a rate command runs, cleared on completion
// - one 32-bit filtered counter per port, plus one per filtered packet
// - counter 0 counts host MAC side, counters 1 and 2 network ports
// - broadcast throttling drops are counted as filtered
// - ingress rate limiting drops are not counted here
// - reading a counter returns its value then clears it; zero after reset
// - counters stop at all ones instead of wrapping
// - regen table: eight 3-bit fields, bits 31:24 reserved read-only
// - each packet's priority is replaced by its table field for queueing
// - after reset each table field equals its own index
`timescale 1ns/1ps
module isr_regs #(
    parameter int unsigned NUM_PORTS       = 3,   // counted ports
    parameter int unsigned NUM_REGEN_PORTS = 2    // ports with a regen table
) (
    input  wire logic                                  hclk,             // core clock
    input  wire logic                                  hresetn,          // async reset, low
    input  wire logic                                  ce,               // clock enable
    input  wire logic                                  hsel,             // slave select
    input  wire logic [31:0]                           haddr,            // byte address
    input  wire logic [1:0]                            htrans,           // transfer type
    input  wire logic                                  hwrite,           // write when high
    input  wire logic [2:0]                            hsize,            // word only
    input  wire logic [31:0]                           hwdata,           // write data
    input  wire logic                                  hready,           // bus ready
    output logic                                       hreadyout,        // slave ready
    output logic [31:0]                                hrdata,           // read data
    output logic [1:0]                                 hresp,            // always okay
    input  wire logic                                  rate_cmd_start,   // command issued
    input  wire logic                                  rate_cmd_done,    // command finished
    input  wire logic [isr_pkg::RATE_DATA_W-1:0]       rate_table_data,  // fetched entry
    output logic                                       rate_cmd_pending, // command running
    input  wire isr_pkg::isr_drop_t [NUM_PORTS-1:0]    drop_ev,          // per-port drops
    input  wire isr_pkg::isr_pkt_t [NUM_REGEN_PORTS-1:0] rx_pkt,         // received prio
    output isr_pkg::isr_pkt_t [NUM_REGEN_PORTS-1:0]    regen_pkt         // regenerated prio
);

    // ==========================================================
    // elaboration checks
    // only three counter and two table addresses exist
    if (NUM_PORTS < 1 || NUM_PORTS > 3) begin : g_bad_ports
        $error("NUM_PORTS must be 1 to 3");
    end
    if (NUM_REGEN_PORTS < 1 || NUM_REGEN_PORTS > 2) begin : g_bad_regen
        $error("NUM_REGEN_PORTS must be 1 or 2");
    end

    // ==========================================================
    // declarations
    localparam logic [15:0] CNT_IDX [3]   = '{isr_pkg::IDX_FILT_CNT_P0,
                                              isr_pkg::IDX_FILT_CNT_P1,
                                              isr_pkg::IDX_FILT_CNT_P2};
    localparam logic [15:0] REGEN_IDX [2] = '{isr_pkg::IDX_REGEN_P0,
                                              isr_pkg::IDX_REGEN_P1};

    logic                              addr_ok;
    logic [isr_pkg::IDX_W-1:0]         addr_idx;
    logic                              acc_take;
    logic                              rd_take;
    logic                              wr_take;
    logic                              wr_dphase;
    logic [isr_pkg::IDX_W-1:0]         wr_idx;
    logic [isr_pkg::RATE_DATA_W-1:0]   rate_rd_data;
    logic [NUM_PORTS-1:0]              cnt_inc;
    logic [NUM_PORTS-1:0]              cnt_clr;
    logic [isr_pkg::CNT_W-1:0]         cnt_val   [NUM_PORTS];
    logic [isr_pkg::REGEN_W-1:0]       regen_tbl [NUM_REGEN_PORTS];
    logic [31:0]                       next_rdata;

    // ==========================================================
    // bus handshake
    // zero wait states; a low clock enable stalls the bus instead of
    // letting a transfer slip past frozen state
    assign hreadyout = ce;
    assign hresp     = isr_pkg::HRESP_OKAY;

    // word-aligned decode of the index field
    always_comb begin
        addr_idx = haddr[isr_pkg::IDX_W+1:2];
        addr_ok  = (haddr[31:isr_pkg::IDX_W+2] == '0) && (haddr[1:0] == 2'h0);
    end

    assign acc_take = hsel && hready && ce && (htrans != isr_pkg::HTRANS_IDLE) && htrans[1];
    assign rd_take  = acc_take && !hwrite;
    assign wr_take  = acc_take && hwrite;

    // write address phase is held until its data phase closes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dphase <= 1'b0;
            wr_idx    <= '0;
        end else if (ce) begin
            wr_dphase <= wr_take && addr_ok;
            wr_idx    <= wr_take ? addr_idx : wr_idx;
        end
    end

    // ==========================================================
    // ingress rate table read-back
    // pending: a new start in the completing cycle keeps it set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_cmd_pending <= 1'b0;
        end else if (ce) begin
            if (rate_cmd_start) begin
                rate_cmd_pending <= 1'b1;
            end else if (rate_cmd_done) begin
                rate_cmd_pending <= 1'b0;
            end
        end
    end

    // fetched entry captured only when a running command ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_rd_data <= isr_pkg::RATE_RD_RESET;
        end else if (ce && rate_cmd_done && rate_cmd_pending) begin
            rate_rd_data <= rate_table_data;
        end
    end

    // ==========================================================
    // per-port filtered counters
    // rate limiting drops have their own tally elsewhere and are
    // deliberately not an input here; a filtered packet that is also
    // throttled is one packet and counts once
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_cnt
        assign cnt_inc[p] = drop_ev[p].filtered || drop_ev[p].bcast_throttle;
        assign cnt_clr[p] = rd_take && addr_ok && addr_idx == CNT_IDX[p];

        isr_filt_counter u_cnt (
            .hclk    (hclk),
            .hresetn (hresetn),
            .ce      (ce),
            .inc     (cnt_inc[p]),
            .clr     (cnt_clr[p]),
            .count   (cnt_val[p])
        );
    end

    // ==========================================================
    // priority regeneration tables
    // only bits 23:0 are stored, so 31:24 cannot be written
    for (genvar t = 0; t < NUM_REGEN_PORTS; t++) begin : g_regen
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                regen_tbl[t] <= isr_pkg::REGEN_RESET;
            end else if (ce && wr_dphase && wr_idx == REGEN_IDX[t]) begin
                regen_tbl[t] <= hwdata[isr_pkg::REGEN_W-1:0];
            end
        end

        isr_regen_map u_map (
            .hclk       (hclk),
            .hresetn    (hresetn),
            .ce         (ce),
            .table_bits (regen_tbl[t]),
            .pkt_in     (rx_pkt[t]),
            .pkt_out    (regen_pkt[t])
        );
    end

    // ==========================================================
    // read mux
    // a read right behind a write to the same table sees the new
    // value, forwarded from the write data still on the bus
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (addr_ok) begin
            if (addr_idx == isr_pkg::IDX_RATE_STATUS) begin
                next_rdata[isr_pkg::PENDING_BIT] = rate_cmd_pending;
            end
            if (addr_idx == isr_pkg::IDX_RATE_RD_DATA) begin
                next_rdata[isr_pkg::RATE_DATA_W-1:0] = rate_rd_data;
            end
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (addr_idx == CNT_IDX[p]) begin
                    next_rdata = cnt_val[p];
                end
            end
            for (int t = 0; t < NUM_REGEN_PORTS; t++) begin
                if (addr_idx == REGEN_IDX[t]) begin
                    next_rdata[isr_pkg::REGEN_W-1:0] =
                        (wr_dphase && wr_idx == REGEN_IDX[t]) ? hwdata[isr_pkg::REGEN_W-1:0] : regen_tbl[t];
                end
            end
        end
    end

    // read data registered at the address phase edge, which is also
    // the edge that clears a counter, so the value returned is the
    // value cleared
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata <= next_rdata;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic                      chk_rd_rate;
    logic                      chk_rd_regen;
    logic                      chk_rd_cnt1;
    assign chk_rd_rate  = rd_take && addr_ok && addr_idx == isr_pkg::IDX_RATE_RD_DATA;
    assign chk_rd_regen = rd_take && addr_ok && addr_idx == isr_pkg::IDX_REGEN_P0;
    assign chk_rd_cnt1  = rd_take && addr_ok && addr_idx == isr_pkg::IDX_FILT_CNT_P1;

    property p_rate_read;
        chk_rd_rate |=> hrdata[31:16] == 16'h0000 && hrdata[15:0] == $past(rate_rd_data);
    endproperty
    a_rate_read: assert property (p_rate_read) else $error("rate read data wrong");

    property p_pend_set;
        ce && rate_cmd_start |=> rate_cmd_pending;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending not set by command");

    property p_pend_clr;
        ce && rate_cmd_done && !rate_cmd_start |=> !rate_cmd_pending;
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared on completion");

    property p_cnt_map;
        chk_rd_cnt1 |=> hrdata == $past(cnt_val[1]) ##1 (cnt_val[1] <= 32'h0000_0002);
    endproperty
    a_cnt_map: assert property (p_cnt_map) else $error("port one counter read wrong");

    property p_bcast;
        ce && drop_ev[0].bcast_throttle && !cnt_clr[0] && cnt_val[0] != isr_pkg::CNT_MAX
            |=> cnt_val[0] == $past(cnt_val[0]) + 32'h0000_0001;
    endproperty
    a_bcast: assert property (p_bcast) else $error("throttled drop not counted");

    property p_reserved;
        chk_rd_regen |=> hrdata[31:24] == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved table bits not zero");

    property p_regen_reset;
        $rose(hresetn) |-> regen_tbl[0] == isr_pkg::REGEN_RESET;
    endproperty
    a_regen_reset: assert property (p_regen_reset) else $error("table not identity after reset");

    property p_tbl_wr;
        ce && wr_dphase && wr_idx == isr_pkg::IDX_REGEN_P0 |=> regen_tbl[0] == $past(hwdata[isr_pkg::REGEN_W-1:0]);
    endproperty
    a_tbl_wr: assert property (p_tbl_wr) else $error("table write lost");

    property p_tbl_hold;
        !(wr_dphase && wr_idx == isr_pkg::IDX_REGEN_P0) |=> $stable(regen_tbl[0]);
    endproperty
    a_tbl_hold: assert property (p_tbl_hold) else $error("table changed without a write");

    property p_rate_cap;
        ce && rate_cmd_done && rate_cmd_pending |=> rate_rd_data == $past(rate_table_data);
    endproperty
    a_rate_cap: assert property (p_rate_cap) else $error("fetched entry not captured");

    property p_rate_keep;
        !(ce && rate_cmd_done && rate_cmd_pending) |=> $stable(rate_rd_data);
    endproperty
    a_rate_keep: assert property (p_rate_keep) else $error("rate read data changed");

    property p_status_read;
        rd_take && addr_ok && addr_idx == isr_pkg::IDX_RATE_STATUS |=> hrdata == {31'h0, $past(rate_cmd_pending)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("pending flag read wrong");

    property p_cnt0_read;
        cnt_clr[0] |=> hrdata == $past(cnt_val[0]) && cnt_val[0] <= 32'h0000_0001;
    endproperty
    a_cnt0_read: assert property (p_cnt0_read) else $error("port zero read did not clear");

    property p_filt2;
        ce && drop_ev[2].filtered && !cnt_clr[2] && cnt_val[2] != isr_pkg::CNT_MAX
            |=> cnt_val[2] == $past(cnt_val[2]) + 32'h0000_0001;
    endproperty
    a_filt2: assert property (p_filt2) else $error("filtered drop not counted");

    property p_frozen;
        !ce |=> $stable(hrdata) && $stable(rate_cmd_pending) && $stable(cnt_val[0]);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved with clock enable low");

    property p_cov_rate;
        ce && rate_cmd_done && rate_cmd_pending ##[1:20] chk_rd_rate;
    endproperty
    c_cov_rate: cover property (p_cov_rate);

    property p_cov_clr_evt;
        cnt_clr[0] && cnt_inc[0];
    endproperty
    c_cov_clr_evt: cover property (p_cov_clr_evt);

    property p_cov_wr_rd;
        wr_take && addr_ok && addr_idx == isr_pkg::IDX_REGEN_P0 ##1 chk_rd_regen;
    endproperty
    c_cov_wr_rd: cover property (p_cov_wr_rd);

endmodule : isr_regs

//--- sim/test_isr_regs.sv
`timescale 1ns/1ps
module test_isr_regs;
    // ==========================================================
    // signals
    logic                        hclk = 1'b0;
    logic                        hresetn = 1'b0;
    logic                        ce = 1'b1;
    logic                        hsel = 1'b0;
    logic [31:0]                 haddr = 32'h0000_0000;
    logic [1:0]                  htrans = 2'h0;
    logic                        hwrite = 1'b0;
    logic [2:0]                  hsize = 3'h2;
    logic [31:0]                 hwdata = 32'h0000_0000;
    logic                        hreadyout;
    logic [31:0]                 hrdata;
    logic [1:0]                  hresp;
    logic                        rate_cmd_start = 1'b0;
    logic                        rate_cmd_done = 1'b0;
    logic [15:0]                 rate_table_data = 16'h0000;
    logic                        rate_cmd_pending;
    isr_pkg::isr_drop_t [2:0]    drop_ev = '0;
    isr_pkg::isr_pkt_t [1:0]     rx_pkt = '0;
    isr_pkg::isr_pkt_t [1:0]     regen_pkt;
    int                          n_mismatch = 0;
    int                          n_tests = 0;
    int                          seed = 53;
    logic [31:0]                 rd;
    logic [31:0]                 cnt [3];
    logic [23:0]                 tbl [2];
    logic [15:0]                 rdat;

    // ==========================================================
    // clock and design
    always #4 hclk = ~hclk;

    isr_regs dut_u (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .rate_cmd_start(rate_cmd_start), .rate_cmd_done(rate_cmd_done),
        .rate_table_data(rate_table_data), .rate_cmd_pending(rate_cmd_pending), .drop_ev(drop_ev),
        .rx_pkt(rx_pkt), .regen_pkt(regen_pkt)
    );

    // ==========================================================
    // helpers
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [2:0] remap(input logic [23:0] t, input int p);
        return t[3*p +: 3];
    endfunction : remap

    // one ahb single transfer; ev rides along with the address phase
    task bus(input logic w, input logic [15:0] idx, input logic [31:0] wd,
             input isr_pkg::isr_drop_t [2:0] ev, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {14'h0000, idx, 2'h0};
        drop_ev <= ev;
        // no cycle count assumed: only the watchdog ends a stalled wait
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans  <= isr_pkg::HTRANS_IDLE;
        hwdata  <= wd;
        drop_ev <= '0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        check("hresp", {30'h0, hresp}, {30'h0, isr_pkg::HRESP_OKAY});
    endtask : bus

    // every priority through both ports, against the bench's copy of the tables
    task regen_sweep;
        for (int k = 0; k < 8; k++) begin
            @(posedge hclk);
            rx_pkt <= {1'b1, k[2:0], 1'b1, k[2:0]};
            @(posedge hclk);
            rx_pkt <= '0;
            #1;
            for (int i = 0; i < 2; i++)
                check("regen_pkt", {28'h0, regen_pkt[i]}, {28'h0, 1'b1, remap(tbl[i], k)});
        end
    endtask : regen_sweep

    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        wrap_up();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values of every register
        bus(0, isr_pkg::IDX_RATE_STATUS, 0, '0, rd);  check("status", rd, 32'h0000_0000);
        bus(0, isr_pkg::IDX_RATE_RD_DATA, 0, '0, rd); check("rate_rd", rd, 32'h0000_0000);
        for (int p = 0; p < 3; p++) begin
            bus(0, isr_pkg::IDX_FILT_CNT_P0 + 16'(p), 0, '0, rd);
            check("cnt_reset", rd, 32'h0000_0000);
            cnt[p] = 32'h0000_0000;
        end
        for (int i = 0; i < 2; i++) begin
            bus(0, isr_pkg::IDX_REGEN_P0 + 16'(i), 0, '0, rd);
            check("regen_reset", rd, 32'h00FA_C688);
            tbl[i] = 24'hFAC688;
        end
        regen_sweep();
        $display("test reset_values done");

        // random tables with reserved bits set, read back at once, then used
        for (int n = 0; n < 3; n++) begin
            for (int i = 0; i < 2; i++) begin
                rd = $random(seed);
                rd[31:24] = 8'hFF;
                tbl[i] = rd[23:0];
                bus(1, isr_pkg::IDX_REGEN_P0 + 16'(i), rd, '0, rd);
                bus(0, isr_pkg::IDX_REGEN_P0 + 16'(i), 0, '0, rd);
                check("regen_rw", rd, {8'h00, tbl[i]});
            end
            regen_sweep();
        end
        $display("test regen_tables done");

        // random drop traffic, both drop kinds and their overlap
        for (int c = 0; c < 60; c++) begin
            @(posedge hclk);
            for (int p = 0; p < 3; p++) begin
                drop_ev[p] <= 2'($random(seed));
            end
            #1;
            for (int p = 0; p < 3; p++)
                if (drop_ev[p] != 2'h0) cnt[p] = cnt[p] + 1;
        end
        @(posedge hclk);
        drop_ev <= '0;
        for (int p = 0; p < 3; p++) begin
            bus(0, isr_pkg::IDX_FILT_CNT_P0 + 16'(p), 0, '0, rd);
            check("cnt_value", rd, cnt[p]);
            bus(0, isr_pkg::IDX_FILT_CNT_P0 + 16'(p), 0, '0, rd);
            check("cnt_cleared", rd, 32'h0000_0000);
        end
        $display("test filtered_counters done");

        // an event in the very cycle of the clearing read must survive
        for (int c = 0; c < 3; c++) begin
            @(posedge hclk);
            drop_ev <= 6'b00_10_00;
        end
        bus(0, isr_pkg::IDX_FILT_CNT_P1, 0, 6'b00_01_00, rd);
        check("cnt_coincide", rd, 32'h0000_0003);
        bus(0, isr_pkg::IDX_FILT_CNT_P1, 0, '0, rd);
        check("cnt_kept", rd, 32'h0000_0001);
        // counters ignore writes; unmapped reads zero
        bus(1, isr_pkg::IDX_FILT_CNT_P0, 32'hFFFF_FFFF, '0, rd);
        bus(0, isr_pkg::IDX_FILT_CNT_P0, 0, '0, rd);  check("cnt_ro", rd, 32'h0000_0000);
        bus(1, 16'h1853, 32'h1234_5678, '0, rd);
        bus(0, 16'h1853, 0, '0, rd);                  check("unmapped", rd, 32'h0000_0000);
        $display("test clear_race done");

        // frozen block stalls the bus and counts nothing
        @(posedge hclk);
        ce <= 1'b0;
        drop_ev <= 6'b11_00_00;
        @(posedge hclk);
        drop_ev <= '0;
        #1 check("hreadyout_low", {31'h0, hreadyout}, 32'h0000_0000);
        @(posedge hclk);
        ce <= 1'b1;
        bus(0, isr_pkg::IDX_FILT_CNT_P2, 0, '0, rd); check("cnt_frozen", rd, 32'h0000_0000);
        $display("test clock_enable done");

        // rate table command: pending, completion, captured data
        for (int n = 0; n < 3; n++) begin
            rdat = 16'($random(seed));
            @(posedge hclk);
            rate_cmd_start <= 1'b1;
            @(posedge hclk);
            rate_cmd_start <= 1'b0;
            #1 check("pending_set", {31'h0, rate_cmd_pending}, 32'h0000_0001);
            bus(0, isr_pkg::IDX_RATE_STATUS, 0, '0, rd); check("status_busy", rd, 32'h0000_0001);
            @(posedge hclk);
            rate_cmd_done <= 1'b1;
            rate_table_data <= rdat;
            @(posedge hclk);
            rate_cmd_done <= 1'b0;
            rate_table_data <= ~rdat;
            #1 check("pending_clr", {31'h0, rate_cmd_pending}, 32'h0000_0000);
            // a stray completion must not overwrite the captured entry
            @(posedge hclk);
            rate_cmd_done <= 1'b1;
            @(posedge hclk);
            rate_cmd_done <= 1'b0;
            bus(0, isr_pkg::IDX_RATE_RD_DATA, 0, '0, rd); check("rate_rd", rd, {16'h0000, rdat});
        end
        $display("test rate_command done");
        wrap_up();
    end
endmodule : test_isr_regs
